//--- hdl/uhr_in_seq.sv
// IN transaction sequencer with retry and NAK counting
module uhr_in_seq (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       isoMode,
  input  wire logic [7:0] nakLimit,
  input  wire logic       rspNak,
  input  wire logic       rspStall,
  input  wire logic       rspNone,
  input  wire logic       rxLast,
  input  wire logic       rxBad,
  output logic            tokenReq,
  output logic            busy,
  output logic            evData,
  output logic            evDrop,
  output logic            evStall,
  output logic            evError,
  output logic            evNakTo
);
  uhr_pkg::uhr_seq_type state_q;
  logic [1:0]           tries_q;
  logic [7:0]           naks_q;
  logic                 fail;

  assign busy    = (state_q == uhr_pkg::SQ_WAIT);
  assign evData  = busy & rxLast & (~rxBad | isoMode);
  assign evDrop  = busy & rxLast & rxBad & ~isoMode;
  assign fail    = evDrop | (busy & rspNone);
  assign evError = fail & ~isoMode
                 & (tries_q == uhr_pkg::RETRY_LIMIT - 2'h1);
  assign evStall = busy & rspStall;
  // A limit of zero never times out
  assign evNakTo = busy & rspNak & ~isoMode & (nakLimit != 8'h00)
                 & (8'(naks_q + 8'h01) >= nakLimit);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q  <= uhr_pkg::SQ_IDLE;
      tokenReq <= 1'b0;
      tries_q  <= 2'h0;
      naks_q   <= 8'h00;
    end else begin
      tokenReq <= 1'b0;
      unique case (state_q)
        uhr_pkg::SQ_IDLE: begin
          if (start) begin
            tokenReq <= 1'b1;
            state_q  <= uhr_pkg::SQ_WAIT;
            tries_q  <= 2'h0;
            naks_q   <= 8'h00;
          end
        end
        uhr_pkg::SQ_WAIT: begin
          if (evData || evError || evNakTo || evStall) begin
            state_q <= uhr_pkg::SQ_IDLE;
          end else if (fail) begin
            tries_q  <= tries_q + 2'h1;
            tokenReq <= 1'b1;
          end else if (rspNak) begin
            naks_q   <= naks_q + 8'h01;
            tokenReq <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

//--- hdl/uhr_pkg.sv
// Constants shared by the receive endpoint status block
package uhr_pkg;
  localparam int ADR_W  = 12;
  localparam int IDX_W  = 10;
  localparam int MAXP_W = 11;
  localparam int NAK_W  = 8;
  localparam int INT_W  = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MAXP   = 10'h114;
  localparam logic [IDX_W-1:0] IDX_CSRL   = 10'h116;
  localparam logic [IDX_W-1:0] IDX_CSRH   = 10'h117;
  localparam logic [IDX_W-1:0] IDX_NAKLIM = 10'h118;
  localparam logic [IDX_W-1:0] IDX_INTST  = 10'h119;
  localparam logic [IDX_W-1:0] IDX_INTMSK = 10'h11A;
  localparam logic [IDX_W-1:0] IDX_RXDATA = 10'h11B;

  // rx_ctrl_status_low fields
  localparam int B_CLEAR_TOGGLE = 7;
  localparam int B_STALL        = 6;
  localparam int B_REQ          = 5;
  localparam int B_FLUSH        = 4;
  localparam int B_CRC_NAKTO    = 3;
  localparam int B_ERROR        = 2;
  localparam int B_FULL         = 1;
  localparam int B_READY        = 0;

  // rx_ctrl_status_high fields
  localparam int H_AUTO_CLEAR = 7;
  localparam int H_ISO        = 6;
  localparam int H_TOGGLE     = 1;

  // rx_interrupt_status fields
  localparam int I_EP    = 0;
  localparam int I_NAKTO = 1;

  localparam logic [7:0]        CSRL_RESET   = 8'h00;
  localparam logic [7:0]        CSRH_RESET   = 8'h00;
  localparam logic [MAXP_W-1:0] MAXP_RESET   = 11'h000;
  localparam logic [NAK_W-1:0]  NAKLIM_RESET = 8'h00;
  localparam logic [INT_W-1:0]  INT_RESET    = 2'h0;

  // Attempts without a data packet before the error flag
  localparam logic [1:0] RETRY_LIMIT = 2'h3;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'h1,
    SQ_WAIT = 2'h2
  } uhr_seq_type;
endpackage

//--- hdl/uhr_rx_ep_status.sv
// Host receive endpoint control and status with Wishbone slave
// How it works
// - Clear-toggle write resets receive data toggle
// - Stall handshake sets sticky flag and interrupt
// - Request bit starts an IN transaction
// - Request bit drops when packet ready sets
// - Flush drops head packet, clears ready
// - Iso bad packet flags bit 3, clears with ready
// - Bulk NAK limit sets bit 3, halts endpoint
// - Three failed bulk attempts set error and interrupt
// - Error reads zero in isochronous mode
// - Bit 1 shows FIFO cannot take packet
// - Data packet sets ready and interrupt
// - Auto-clear drops ready after full packet
// - Low control byte resets to zero
//
// Register access over Wishbone was chosen for this implementation.
module uhr_rx_ep_status #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq,
  output logic             tokenReq,
  output logic             dataToggle,
  input  wire logic        rspNak,
  input  wire logic        rspStall,
  input  wire logic        rspNone,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxLast,
  input  wire logic        rxBad
);
  localparam int MW = uhr_pkg::MAXP_W;
  localparam int IW = uhr_pkg::INT_W;

  logic          ack_q;
  logic          req;
  logic          wrReq;
  logic          rdReq;
  logic          stall_q;
  logic          request_packet_q;
  logic          nakTo_q;
  logic          error_q;
  logic          ready_q;
  logic          pend_q;
  logic          auto_clear_q;
  logic          iso_q;
  logic [MW-1:0] maxPay_q;
  logic [7:0]    nakLim_q;
  logic [IW-1:0] intStat_q;
  logic [IW-1:0] intMask_q;
  logic [MW-1:0] unload_q;
  logic [31:0]   rdVal;
  logic [7:0]    csrlVal;
  logic          wCsrl;
  logic          clrTog;
  logic          flush;
  logic          swRdyClr;
  logic          popByte;
  logic          autoRel;
  logic          dropHead;
  logic          readySet;
  logic          start;
  logic          busy;
  logic          evData;
  logic          evDrop;
  logic          evStall;
  logic          evError;
  logic          evNakTo;
  logic          pktAvail;
  logic          fifoFull;
  logic          headBad;
  logic [7:0]    fifoData;

  function automatic logic hit(input logic [11:0] a,
                               input logic [9:0]  idx);
    return a[11:2] == idx;
  endfunction

  // Bus slave: ack one cycle after the strobe, dropped the next
  assign req   = cyc_i & stb_i & ~ack_q;
  assign wrReq = req & we_i;
  assign rdReq = req & ~we_i;
  assign ack_o = ack_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  assign wCsrl    = wrReq & sel_i[0] & hit(adr_i, uhr_pkg::IDX_CSRL);
  assign clrTog   = wCsrl & dat_i[uhr_pkg::B_CLEAR_TOGGLE];
  assign flush    = wCsrl & dat_i[uhr_pkg::B_FLUSH];
  assign swRdyClr = wCsrl & ~dat_i[uhr_pkg::B_READY] & ready_q;
  assign popByte  = rdReq & ready_q & hit(adr_i, uhr_pkg::IDX_RXDATA);
  assign autoRel  = popByte & auto_clear_q
                  & (MW'(unload_q + 11'h001) == maxPay_q);
  assign dropHead = swRdyClr | flush | autoRel;
  assign readySet = pktAvail & ~ready_q & ~dropHead;
  // A halted or full endpoint issues no token
  assign start    = request_packet_q & ~nakTo_q & ~fifoFull & ~pend_q
                  & ~stall_q;

  uhr_in_seq u_seq (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .start    (start),
    .isoMode  (iso_q),
    .nakLimit (nakLim_q),
    .rspNak   (rspNak),
    .rspStall (rspStall),
    .rspNone  (rspNone),
    .rxLast   (rxLast),
    .rxBad    (rxBad),
    .tokenReq (tokenReq),
    .busy     (busy),
    .evData   (evData),
    .evDrop   (evDrop),
    .evStall  (evStall),
    .evError  (evError),
    .evNakTo  (evNakTo)
  );

  uhr_rx_fifo #(
    .DW    (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .wrValid  (rxValid & busy),
    .wrData   (rxByte),
    .wrLast   (evData),
    .wrBad    (rxBad),
    .wrAbort  (evDrop),
    .rdPop    (popByte),
    .dropHead (dropHead),
    .rdData   (fifoData),
    .headBad  (headBad),
    .pktAvail (pktAvail),
    .full     (fifoFull)
  );

  // Commit becomes visible to the FIFO count one cycle after evData
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= evData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ready_q <= uhr_pkg::CSRL_RESET[uhr_pkg::B_READY];
    end else if (readySet) begin
      ready_q <= 1'b1;
    end else if (dropHead) begin
      ready_q <= 1'b0;
    end
  end

  // A fresh write of the request bit wins over the hardware drop
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      request_packet_q <= uhr_pkg::CSRL_RESET[uhr_pkg::B_REQ];
    end else if (wCsrl) begin
      request_packet_q <= dat_i[uhr_pkg::B_REQ];
    end else if (pend_q || readySet || evStall || evError || evNakTo) begin
      request_packet_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stall_q <= uhr_pkg::CSRL_RESET[uhr_pkg::B_STALL];
    end else if (evStall) begin
      stall_q <= 1'b1;
    end else if (wCsrl && !dat_i[uhr_pkg::B_STALL]) begin
      stall_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      error_q <= uhr_pkg::CSRL_RESET[uhr_pkg::B_ERROR];
    end else if (evError) begin
      error_q <= 1'b1;
    end else if (wCsrl && !dat_i[uhr_pkg::B_ERROR]) begin
      error_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      nakTo_q <= uhr_pkg::CSRL_RESET[uhr_pkg::B_CRC_NAKTO];
    end else if (evNakTo) begin
      nakTo_q <= 1'b1;
    end else if (wCsrl && !dat_i[uhr_pkg::B_CRC_NAKTO]) begin
      nakTo_q <= 1'b0;
    end
  end

  // Iso packets carry no toggle sequence, so only bulk advances it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dataToggle <= uhr_pkg::CSRH_RESET[uhr_pkg::H_TOGGLE];
    end else if (clrTog) begin
      dataToggle <= 1'b0;
    end else if (evData && !iso_q) begin
      dataToggle <= ~dataToggle;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      unload_q <= uhr_pkg::MAXP_RESET;
    end else if (dropHead) begin
      unload_q <= uhr_pkg::MAXP_RESET;
    end else if (popByte) begin
      unload_q <= MW'(unload_q + 11'h001);
    end
  end

  // Software-written configuration
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      auto_clear_q <= uhr_pkg::CSRH_RESET[uhr_pkg::H_AUTO_CLEAR];
      iso_q     <= uhr_pkg::CSRH_RESET[uhr_pkg::H_ISO];
      maxPay_q  <= uhr_pkg::MAXP_RESET;
      nakLim_q  <= uhr_pkg::NAKLIM_RESET;
      intMask_q <= uhr_pkg::INT_RESET;
    end else if (wrReq) begin
      if (sel_i[0] && hit(adr_i, uhr_pkg::IDX_CSRH)) begin
        auto_clear_q <= dat_i[uhr_pkg::H_AUTO_CLEAR];
        iso_q     <= dat_i[uhr_pkg::H_ISO];
      end
      if (hit(adr_i, uhr_pkg::IDX_MAXP)) begin
        if (sel_i[0]) begin
          maxPay_q[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          maxPay_q[MW-1:8] <= dat_i[MW-1:8];
        end
      end
      if (sel_i[0] && hit(adr_i, uhr_pkg::IDX_NAKLIM)) begin
        nakLim_q <= dat_i[7:0];
      end
      if (sel_i[0] && hit(adr_i, uhr_pkg::IDX_INTMSK)) begin
        intMask_q <= dat_i[IW-1:0];
      end
    end
  end

  // Read clears status, but an event in the same cycle survives
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      intStat_q <= uhr_pkg::INT_RESET;
    end else begin
      intStat_q[uhr_pkg::I_EP] <= (intStat_q[uhr_pkg::I_EP]
          & ~(rdReq && hit(adr_i, uhr_pkg::IDX_INTST)))
          | readySet | evStall | evError;
      intStat_q[uhr_pkg::I_NAKTO] <= (intStat_q[uhr_pkg::I_NAKTO]
          & ~(rdReq && hit(adr_i, uhr_pkg::IDX_INTST)))
          | evNakTo;
    end
  end

  assign irq = |(intStat_q & intMask_q);

  always_comb begin
    csrlVal                        = 8'h00;
    csrlVal[uhr_pkg::B_STALL]      = stall_q;
    csrlVal[uhr_pkg::B_REQ]        = request_packet_q;
    csrlVal[uhr_pkg::B_CRC_NAKTO]  = iso_q ? (ready_q & headBad)
                                           : nakTo_q;
    csrlVal[uhr_pkg::B_ERROR]      = error_q & ~iso_q;
    csrlVal[uhr_pkg::B_FULL]       = fifoFull;
    csrlVal[uhr_pkg::B_READY]      = ready_q;
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    if (hit(adr_i, uhr_pkg::IDX_CSRL)) begin
      rdVal[7:0] = csrlVal;
    end else if (hit(adr_i, uhr_pkg::IDX_CSRH)) begin
      rdVal[uhr_pkg::H_AUTO_CLEAR] = auto_clear_q;
      rdVal[uhr_pkg::H_ISO]        = iso_q;
      rdVal[uhr_pkg::H_TOGGLE]     = dataToggle;
    end else if (hit(adr_i, uhr_pkg::IDX_MAXP)) begin
      rdVal[MW-1:0] = maxPay_q;
    end else if (hit(adr_i, uhr_pkg::IDX_NAKLIM)) begin
      rdVal[7:0] = nakLim_q;
    end else if (hit(adr_i, uhr_pkg::IDX_INTST)) begin
      rdVal[IW-1:0] = intStat_q;
    end else if (hit(adr_i, uhr_pkg::IDX_INTMSK)) begin
      rdVal[IW-1:0] = intMask_q;
    end else if (hit(adr_i, uhr_pkg::IDX_RXDATA)) begin
      rdVal[7:0] = ready_q ? fifoData : 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dat_o <= 32'h0000_0000;
    end else if (rdReq) begin
      dat_o <= rdVal;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  bus_ack_pulse_a: assert property (req |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse after request");
  toggle_clear_a: assert property (clrTog |=> !dataToggle)
    else $error("toggle not cleared");
  stall_set_a: assert property (
    evStall |=> stall_q && intStat_q[uhr_pkg::I_EP])
    else $error("stall event not recorded");
  stall_hold_a: assert property (
    stall_q && !(wCsrl && !dat_i[uhr_pkg::B_STALL]) |=> stall_q)
    else $error("stall flag lost without a clearing write");
  token_start_a: assert property (
    start && !busy |=> tokenReq ##1 busy)
    else $error("request did not start an IN transaction");
  req_drop_a: assert property (
    readySet && !wCsrl |=> ready_q && !request_packet_q)
    else $error("request bit not dropped with ready");
  flush_clear_a: assert property (
    flush && ready_q |=> !ready_q)
    else $error("flush left ready set");
  iso_err_a: assert property (
    iso_q && !ready_q |-> !csrlVal[uhr_pkg::B_CRC_NAKTO])
    else $error("iso data error without ready");
  nak_halt_a: assert property (
    evNakTo |=> nakTo_q ##0 !tokenReq [*2])
    else $error("endpoint not halted after NAK limit");
  error_set_a: assert property (
    evError |=> error_q && intStat_q[uhr_pkg::I_EP])
    else $error("retry error not recorded");
  iso_error_zero_a: assert property (
    iso_q |-> !csrlVal[uhr_pkg::B_ERROR])
    else $error("error bit visible in iso mode");
  full_no_token_a: assert property (
    csrlVal[uhr_pkg::B_FULL] && !busy |=> !tokenReq)
    else $error("token issued while FIFO full");
  ready_set_a: assert property (
    evData |=> ##1 ready_q)
    else $error("data packet did not raise ready");
  auto_clear_a: assert property (
    autoRel |=> !ready_q ##0 unload_q == uhr_pkg::MAXP_RESET)
    else $error("auto-clear did not drop ready");
  reset_value_a: assert property (
    $rose(reset_n) |-> csrlVal == uhr_pkg::CSRL_RESET)
    else $error("low control byte not zero after reset");
endmodule

//--- hdl/uhr_rx_fifo.sv
// Double-buffered packet FIFO for the receive endpoint
module uhr_rx_fifo #(
  parameter int DW    = 8,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          wrValid,
  input  wire logic [DW-1:0] wrData,
  input  wire logic          wrLast,
  input  wire logic          wrBad,
  input  wire logic          wrAbort,
  input  wire logic          rdPop,
  input  wire logic          dropHead,
  output logic      [DW-1:0] rdData,
  output logic               headBad,
  output logic               pktAvail,
  output logic               full
);
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] basePtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW-1:0] endPtr_q [2];
  logic [1:0]    bad_q;
  logic          wrSlot_q;
  logic          rdSlot_q;
  logic [1:0]    count_q;
  logic          accept;
  logic          commit;
  logic          drop;

  assign full     = (count_q == 2'h2);
  assign pktAvail = (count_q != 2'h0);
  assign rdData   = mem[rdPtr_q];
  assign headBad  = bad_q[rdSlot_q];
  assign accept   = wrValid & ~full & ~wrAbort;
  assign commit   = accept & wrLast;
  assign drop     = dropHead & pktAvail;

  always_ff @(posedge mclk) begin
    if (accept) begin
      mem[wrPtr_q] <= wrData;
    end
  end

  // An aborted packet rewinds to the last committed boundary
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrPtr_q     <= '0;
      basePtr_q   <= '0;
      endPtr_q[0] <= '0;
      endPtr_q[1] <= '0;
      bad_q       <= 2'h0;
      wrSlot_q    <= 1'b0;
    end else if (wrAbort) begin
      wrPtr_q <= basePtr_q;
    end else if (accept) begin
      wrPtr_q <= wrPtr_q + 1'b1;
      if (commit) begin
        basePtr_q          <= wrPtr_q + 1'b1;
        endPtr_q[wrSlot_q] <= wrPtr_q + 1'b1;
        bad_q[wrSlot_q]    <= wrBad;
        wrSlot_q           <= ~wrSlot_q;
      end
    end
  end

  // Dropping the head jumps over whatever of it was not unloaded
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdPtr_q  <= '0;
      rdSlot_q <= 1'b0;
    end else if (drop) begin
      rdPtr_q  <= endPtr_q[rdSlot_q];
      rdSlot_q <= ~rdSlot_q;
    end else if (rdPop && pktAvail) begin
      rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_q <= 2'h0;
    end else if (commit && !drop) begin
      count_q <= count_q + 2'h1;
    end else if (drop && !commit) begin
      count_q <= count_q - 2'h1;
    end
  end
endmodule

//--- tb/uhr_rx_ep_status_tb.sv
// Register-level bench for the receive endpoint status block
module uhr_rx_ep_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic        ack_o, irq, tokenReq, dataToggle;
  logic        rspNak, rspStall, rspNone, rxValid, rxLast, rxBad;
  logic [7:0]  rxByte;
  logic [2:0]  mode = 3'h0;
  logic [3:0]  gap = 4'h0;
  int          fail_count = 0;
  int          comparisons = 0;
  int          tokens = 0;
  int          cycles = 0;
  int          t;

  uhr_rx_ep_status #(.FIFO_DEPTH(16)) u_uhr_rx_ep_status (
    .mclk(mclk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq(irq), .tokenReq(tokenReq),
    .dataToggle(dataToggle), .rspNak(rspNak), .rspStall(rspStall),
    .rspNone(rspNone), .rxValid(rxValid), .rxByte(rxByte),
    .rxLast(rxLast), .rxBad(rxBad));

  uhr_usb_dev_model u_uhr_usb_dev_model (
    .mclk(mclk), .reset_n(reset_n), .tokenReq(tokenReq), .mode(mode),
    .pktLen(8'h04), .gap(gap), .rspNak(rspNak), .rspStall(rspStall),
    .rspNone(rspNone), .rxValid(rxValid), .rxByte(rxByte),
    .rxLast(rxLast), .rxBad(rxBad));

  initial begin
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (tokenReq === 1'b1) tokens <= tokens + 1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; waits for ack with no assumed latency
  task automatic wb(input logic w, input logic [9:0] idx,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    check(q, exp);
  endtask

  task automatic waitSet(input logic [7:0] mask);
    int n;
    n = 0;
    do begin
      wb(1'b0, uhr_pkg::IDX_CSRL, 32'h0);
      n++;
    end while ((q[7:0] & mask) == 8'h00 && n < 100);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    rd(uhr_pkg::IDX_CSRH, 32'h0);
    rd(10'h100, 32'h0);
    wb(1'b1, uhr_pkg::IDX_INTMSK, 32'h3);
    wb(1'b1, uhr_pkg::IDX_MAXP, 32'h4);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h20);
    waitSet(8'h01);
    check(q, 32'h01);
    check({31'h0, irq}, 32'h1);
    check(32'(tokens), 32'h1);
    rd(uhr_pkg::IDX_INTST, 32'h1);
    rd(uhr_pkg::IDX_INTST, 32'h0);
    check({31'h0, irq}, 32'h0);
    for (int i = 0; i < 4; i++) rd(uhr_pkg::IDX_RXDATA, 32'hA0 + i);
    rd(uhr_pkg::IDX_CSRL, 32'h1);
    check({31'h0, dataToggle}, 32'h1);
    // Also drops packet ready, which software owes here
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h80);
    check({31'h0, dataToggle}, 32'h0);
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    // Auto-clear after a full-size unload
    wb(1'b1, uhr_pkg::IDX_CSRH, 32'h80);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h20);
    waitSet(8'h01);
    for (int i = 0; i < 4; i++) rd(uhr_pkg::IDX_RXDATA, 32'hA0 + i);
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    // Fill both slots, then flush them one by one
    wb(1'b1, uhr_pkg::IDX_CSRH, 32'h0);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h20);
    waitSet(8'h01);
    gap <= 4'h6;
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h21);
    waitSet(8'h02);
    // Poll may land between the commit and the request drop
    rd(uhr_pkg::IDX_CSRL, 32'h03);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h11);
    wb(1'b0, uhr_pkg::IDX_CSRL, 32'h0);
    check(q & 32'h12, 32'h0);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h11);
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    rd(uhr_pkg::IDX_INTST, 32'h1);
    // Stall with the interrupt masked, then unmasked
    wb(1'b1, uhr_pkg::IDX_INTMSK, 32'h0);
    mode <= 3'h2;
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h20);
    waitSet(8'h40);
    check(q, 32'h40);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, uhr_pkg::IDX_INTMSK, 32'h3);
    check({31'h0, irq}, 32'h1);
    rd(uhr_pkg::IDX_INTST, 32'h1);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h40);
    rd(uhr_pkg::IDX_CSRL, 32'h40);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h0);
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    // Three silent attempts
    mode <= 3'h3;
    t = tokens;
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h20);
    waitSet(8'h04);
    check(q, 32'h04);
    check(32'(tokens - t), 32'h3);
    rd(uhr_pkg::IDX_INTST, 32'h1);
    // Error still stored, but iso mode must hide it
    wb(1'b1, uhr_pkg::IDX_CSRH, 32'h40);
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    wb(1'b1, uhr_pkg::IDX_CSRH, 32'h0);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h0);
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    // NAK limit halts the bulk endpoint
    mode <= 3'h1;
    wb(1'b1, uhr_pkg::IDX_NAKLIM, 32'h3);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h20);
    waitSet(8'h08);
    check(q, 32'h08);
    rd(uhr_pkg::IDX_INTST, 32'h2);
    // Request again while the timeout bit is kept: must stay halted
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h28);
    t = tokens;
    repeat (20) @(posedge mclk);
    check(32'(tokens - t), 32'h0);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h0);
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    // Isochronous: corrupt packet, then endless silence
    wb(1'b1, uhr_pkg::IDX_CSRH, 32'h40);
    mode <= 3'h4;
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h20);
    waitSet(8'h01);
    check(q, 32'h09);
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h0);
    rd(uhr_pkg::IDX_CSRL, 32'h0);
    mode <= 3'h3;
    wb(1'b1, uhr_pkg::IDX_CSRL, 32'h20);
    repeat (80) @(posedge mclk);
    rd(uhr_pkg::IDX_CSRL, 32'h20);
    summarize();
  end
endmodule

//--- tb/uhr_usb_dev_model.sv
// Peripheral model answering IN tokens with data, NAK, STALL or silence
module uhr_usb_dev_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       tokenReq,
  input  wire logic [2:0] mode,
  input  wire logic [7:0] pktLen,
  input  wire logic [3:0] gap,
  output logic            rspNak,
  output logic            rspStall,
  output logic            rspNone,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  output logic            rxLast,
  output logic            rxBad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       act;
  logic [3:0] wt;
  logic [7:0] idx;

  // Mode 0 good data, 1 NAK, 2 STALL, 3 no answer, 4 corrupted data
  always_ff @(posedge mclk) begin
    {rspNak, rspStall, rspNone, rxValid, rxLast, rxBad} <= 6'h00;
    // Byte lane toggles outside a packet so stale data is never read
    rxByte <= ~rxByte;
    if (!reset_n) begin
      act    <= 1'b0;
      rxByte <= 8'h00;
    end else if (tokenReq) begin
      act <= 1'b1;
      wt  <= gap;
      idx <= 8'h00;
    end else if (act && wt != 4'h0) begin
      wt <= wt - 4'h1;
    end else if (act) begin
      case (mode)
        3'h1: begin rspNak <= 1'b1; act <= 1'b0; end
        3'h2: begin rspStall <= 1'b1; act <= 1'b0; end
        3'h3: begin rspNone <= 1'b1; act <= 1'b0; end
        default: begin
          rxValid <= 1'b1;
          rxByte  <= 8'hA0 + idx;
          idx     <= idx + 8'h01;
          if (idx == pktLen - 8'h01) begin
            rxLast <= 1'b1;
            rxBad  <= (mode == 3'h4);
            act    <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule
